/* rtl/apfc_top.sv */
// Converter sequencer with power-fail compare and AXI4-Lite registers
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module apfc_top
  import apfc_pkg::*;
(
  // Clock and reset
  input  wire logic                       CLK_SYS,
  input  wire logic                       RST_N,
  // AXI4-Lite write address
  input  wire logic                       S_AXI_AWVALID,
  output logic                            S_AXI_AWREADY,
  input  wire logic [apfc_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  // AXI4-Lite write data
  input  wire logic                       S_AXI_WVALID,
  output logic                            S_AXI_WREADY,
  input  wire logic [31:0]                S_AXI_WDATA,
  input  wire logic [3:0]                 S_AXI_WSTRB,
  // AXI4-Lite write response
  output logic                            S_AXI_BVALID,
  input  wire logic                       S_AXI_BREADY,
  output logic [1:0]                      S_AXI_BRESP,
  // AXI4-Lite read address
  input  wire logic                       S_AXI_ARVALID,
  output logic                            S_AXI_ARREADY,
  input  wire logic [apfc_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  // AXI4-Lite read data
  output logic                            S_AXI_RVALID,
  input  wire logic                       S_AXI_RREADY,
  output logic [31:0]                     S_AXI_RDATA,
  output logic [1:0]                      S_AXI_RRESP,
  // Analog front end
  input  wire logic                       CMP_HIGH,
  output logic [apfc_pkg::CHAN_W-1:0]     CH_SEL,
  output logic                            SAMPLE_HOLD,
  output logic [apfc_pkg::RES_W-1:0]      DAC_TAP,
  output logic                            CONV_ENABLE,
  // Power and interrupt
  input  wire logic                       STANDBY,
  output logic                            CONV_END_IRQ
);
  import apfc_pkg::*;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001, // Stopped
    ST_DELAY  = 4'b0010, // Start delay
    ST_SAMPLE = 4'b0100, // Sample and hold open
    ST_CONV   = 4'b1000  // Bit decisions
  } apfc_state_t;
  localparam int ST_SAMPLE_BIT = 2; // Sample state bit

  typedef struct packed {
    apfc_state_t      st;      // Sequencer state
    logic [CNT_W-1:0] cnt;     // Cycles in conversion
    logic [CNT_W-1:0] scnt;    // Cycles in bit step
    logic [7:0]       mode;    // Converter mode reg
    logic [CHAN_W-1:0] chan;   // Channel select reg
    logic [7:0]       cmpm;    // Compare mode reg
    logic [7:0]       thr;     // Compare threshold reg
    logic [15:0]      res;     // Conversion result reg
    logic             upd;     // Result stored pulse
    logic             irq;     // Interrupt pulse
    logic             sclr;    // Approximation clear
    logic             sstep;   // Approximation step
    logic             cmp1;    // Comparator sync 1
    logic             cmp2;    // Comparator sync 2
    logic             awa;     // Write address held
    logic [ADDR_W-1:0] waddr;  // Held write address
    logic             wa;      // Write data held
    logic [31:0]      wdata;   // Held write data
    logic [3:0]       wstrb;   // Held byte strobes
    logic             awready; // Address ready
    logic             wready;  // Data ready
    logic             bvalid;  // Response valid
    logic [1:0]       bresp;   // Response code
    logic             arready; // Read address ready
    logic             rvalid;  // Read data valid
    logic [31:0]      rdata;   // Read data
    logic [1:0]       rresp;   // Read response code
  } apfc_regs_t;

  // ****************************************
  // Signals
  // ****************************************
  logic             rst_s1;  // Reset sync stage 1
  logic             rst_n;   // Synchronised reset
  apfc_regs_t       r;       // Registered state
  apfc_regs_t       n;       // Next state
  apfc_tim_t        tim;     // Timing of rate field
  logic             wr_go;   // Write performed now
  logic             reg_wr;  // Control reg written
  logic [THR_W-1:0] hi;      // Upper result bits
  logic             cond;    // Interrupt condition
  logic [RES_W-1:0] sar_tap; // Approximation value

  // ****************************************
  // Reset release
  // ****************************************
  // Two stage release of the asynchronous reset
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // ****************************************
  // Approximation register
  // ****************************************
  apfc_sar u_sar (
    .clk      (CLK_SYS),
    .rst_n    (rst_n),
    .clear    (r.sclr),
    .step     (r.sstep),
    .cmp_high (r.cmp2),
    .tap      (sar_tap)
  );

  // ****************************************
  // Next state
  // ****************************************
  // Bus slave, register file and conversion sequencer
  always_comb
  begin
    n = r;
    reg_wr = 1'b0;
    n.upd = 1'b0;
    n.irq = 1'b0;
    n.sclr = 1'b0;
    n.sstep = 1'b0;
    // Comparator passes two flops
    n.cmp1 = CMP_HIGH;
    n.cmp2 = r.cmp1;
    tim = rate_timing(r.mode[RATE_LSB +: RATE_W]); // R2
    // Upper result bits against threshold
    hi = sar_tap[RES_W-1 -: THR_W]; // R20
    if (!r.cmpm[CMP_EN])
      cond = 1'b1; // R3
    else if (r.cmpm[CMP_COND])
      cond = (hi < r.thr); // R11
    else
      cond = (hi >= r.thr); // R10

    // Capture write address and data
    if (S_AXI_AWVALID && r.awready)
    begin
      n.awa = 1'b1;
      n.waddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && r.wready)
    begin
      n.wa = 1'b1;
      n.wdata = S_AXI_WDATA;
      n.wstrb = S_AXI_WSTRB;
    end

    // Perform write once both halves are held
    wr_go = r.awa && r.wa && !r.bvalid;
    if (wr_go)
    begin
      n.awa = 1'b0;
      n.wa = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      unique case (r.waddr)
        OFS_MODE:
        begin
          // Start, rate and enable bits
          if (r.wstrb[0])
          begin
            n.mode = r.wdata[7:0]; // R4
            reg_wr = 1'b1;
          end
        end
        OFS_CHAN:
        begin
          // Single selected channel
          if (r.wstrb[0])
          begin
            n.chan = r.wdata[CHAN_W-1:0]; // R1
            reg_wr = 1'b1;
          end
        end
        OFS_CMPM:
        begin
          // Only enable and condition bits kept
          if (r.wstrb[0])
          begin
            n.cmpm = REG_RST;
            n.cmpm[CMP_EN] = r.wdata[CMP_EN]; // R3
            n.cmpm[CMP_COND] = r.wdata[CMP_COND]; // R9
            reg_wr = 1'b1;
          end
        end
        OFS_THR:
        begin
          // Threshold byte
          if (r.wstrb[0])
          begin
            n.thr = r.wdata[THR_W-1:0]; // R20
            reg_wr = 1'b1;
          end
        end
        OFS_RES:
        begin
          // Result is read only, write ignored
          n.bresp = RESP_OKAY;
        end
        default:
          n.bresp = RESP_SLVERR; // Unmapped
      endcase
    end
    // Response taken by master
    if (r.bvalid && S_AXI_BREADY)
      n.bvalid = 1'b0;
    n.awready = !n.awa && !n.bvalid;
    n.wready = !n.wa && !n.bvalid;

    // Read address taken, data registered
    if (S_AXI_ARVALID && r.arready)
    begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = 32'h0000_0000;
      unique case (S_AXI_ARADDR)
        OFS_MODE: n.rdata[7:0] = r.mode;
        OFS_CHAN: n.rdata[CHAN_W-1:0] = r.chan;
        OFS_RES:  n.rdata[15:0] = r.res; // R19
        OFS_CMPM: n.rdata[7:0] = r.cmpm;
        OFS_THR:  n.rdata[7:0] = r.thr;
        default:  n.rresp = RESP_SLVERR; // Unmapped
      endcase
    end
    // Read data taken by master
    if (r.rvalid && S_AXI_RREADY)
      n.rvalid = 1'b0;
    n.arready = !n.rvalid;

    // Conversion sequencer
    if (STANDBY || !n.mode[START_BIT])
    begin
      // Standby or start bit clear stops at once
      n.st = ST_IDLE; // R8 R18
      n.cnt = '0;
      n.scnt = '0;
    end
    else if (r.st == ST_IDLE)
    begin
      // Fresh start runs the start delay first
      n.st = ST_DELAY; // R4
      n.cnt = '0;
    end
    else if (reg_wr)
    begin
      // Write aborts, restart sampling now
      n.st = ST_SAMPLE; // R7 R16
      n.cnt = '0;
      n.sclr = 1'b1;
    end
    else
    begin
      unique case (r.st)
        ST_DELAY:
        begin
          // Wait out the start delay
          if (r.cnt == tim.dly - 9'h001)
          begin
            n.st = ST_SAMPLE;
            n.cnt = '0;
            n.sclr = 1'b1;
          end
          else
            n.cnt = r.cnt + 9'h001;
        end
        ST_SAMPLE:
        begin
          // Sampling is part of conversion time
          n.cnt = r.cnt + 9'h001; // R17
          if (r.cnt == tim.samp - 9'h001)
          begin
            n.st = ST_CONV;
            n.scnt = '0;
          end
        end
        ST_CONV:
        begin
          // One bit decision per step period
          n.cnt = r.cnt + 9'h001;
          n.scnt = r.scnt + 9'h001;
          if (r.scnt == tim.step - 9'h001)
          begin
            n.sstep = 1'b1;
            n.scnt = '0;
          end
          if (r.cnt == tim.conv - 9'h001)
          begin
            // Store result, overwrite unread one
            n.res = {sar_tap, 6'h00}; // R5 R9 R12 R19
            n.upd = 1'b1;
            n.irq = cond; // R5 R9 R21
            // Next conversion follows at once
            n.st = ST_SAMPLE; // R6
            n.cnt = '0;
            n.sclr = 1'b1;
          end
        end
        ST_IDLE:
          n.cnt = '0;
        default:
        begin
          // Illegal code recovers to idle
          n.st = ST_IDLE;
          n.cnt = '0;
        end
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // All sequencer and bus state of the block in one register
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.st <= ST_IDLE;
    end
    else
      r <= n;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign S_AXI_AWREADY = r.awready;
  assign S_AXI_WREADY  = r.wready;
  assign S_AXI_BVALID  = r.bvalid;
  assign S_AXI_BRESP   = r.bresp;
  assign S_AXI_ARREADY = r.arready;
  assign S_AXI_RVALID  = r.rvalid;
  assign S_AXI_RDATA   = r.rdata;
  assign S_AXI_RRESP   = r.rresp;
  assign CH_SEL        = r.chan;
  assign SAMPLE_HOLD   = r.st[ST_SAMPLE_BIT];
  assign DAC_TAP       = sar_tap;
  assign CONV_ENABLE   = r.mode[EN_BIT];
  assign CONV_END_IRQ  = r.irq;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!rst_n);

  irq_pulse_a: assert property (r.irq |=> !r.irq) // R21
    else $error("interrupt held longer than one cycle");

  irq_upd_a: assert property (r.irq |-> r.upd) // R21
    else $error("interrupt without result update");

  norm_irq_a: assert property ( // R5
    (r.upd && !r.cmpm[CMP_EN]) |-> r.irq)
    else $error("normal mode result without interrupt");

  pf_ge_a: assert property ( // R10
    (r.upd && r.cmpm[CMP_EN] && !r.cmpm[CMP_COND])
    |-> (r.irq == (r.res[RES_MSB -: THR_W] >= r.thr)))
    else $error("wrong interrupt for high at or above threshold");

  pf_lt_a: assert property ( // R11
    (r.upd && r.cmpm[CMP_EN] && r.cmpm[CMP_COND])
    |-> (r.irq == (r.res[RES_MSB -: THR_W] < r.thr)))
    else $error("wrong interrupt for high below threshold");

  res_pad_a: assert property (r.res[RES_PAD-1:0] == 6'h00) // R19
    else $error("result low bits not zero");

  stop_now_a: assert property ( // R8
    (wr_go && r.waddr == OFS_MODE && r.wstrb[0] && !r.wdata[START_BIT])
    |=> (r.st == ST_IDLE && !r.upd) [*2])
    else $error("start bit clear did not stop conversion");

  abort_restart_a: assert property ( // R7
    (reg_wr && n.mode[START_BIT] && !STANDBY && r.st != ST_IDLE)
    |=> (r.st == ST_SAMPLE && r.cnt == '0 && !r.upd && r.sclr))
    else $error("register write did not restart conversion");

  chain_next_a: assert property ( // R6
    (r.upd && r.mode[START_BIT]) |-> (r.st == ST_SAMPLE && r.sclr))
    else $error("next conversion did not follow");

  standby_stop_a: assert property (STANDBY |=> r.st == ST_IDLE) // R18
    else $error("conversion ran in standby");

  conv_time_a: assert property ( // R17
    r.upd |-> ($past(r.cnt) ==
      $past(tim.conv) - 9'h001))
    else $error("conversion time does not match rate");
endmodule
`default_nettype wire

/* inc/apfc_pkg.sv */
// Constants, register map and rate timing of the converter sequencer
// Operation
// R1: Convert only the one selected channel
// R2: Channel and rate fields steer later conversions
// R3: Compare enable picks plain or power-fail
// R4: Start bit one begins converting
// R5: Normal mode stores result, raises interrupt
// R6: Next conversion follows at once
// R7: Register write aborts and restarts conversion
// R8: Start bit zero halts conversion at once
// R9: Power-fail stores, compares, gates interrupt
// R10: Condition zero: interrupt when high >= threshold
// R11: Condition one: interrupt when high < threshold
// R12: Unread result is overwritten by newer
// R13: Software waits 14 us enable to start
// R14: Skipping enable means discard first result
// R15: Power-fail use always needs enable first
// R16: Interval after channel change equals conversion time
// R17: Conversion time includes the sampling time
// R18: Standby stops converting
// R19: Result is 16 bits, left-justified, low zero
// R20: Threshold is 8 bits against high bits
// R21: Interrupt is one pulse with result update
`default_nettype none
package apfc_pkg;
  // ****************************************
  // Register map, byte addresses
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_MODE = 8'h00; // Converter mode
  localparam logic [7:0] OFS_CHAN = 8'h04; // Channel select
  localparam logic [7:0] OFS_RES  = 8'h08; // Conversion result
  localparam logic [7:0] OFS_CMPM = 8'h0c; // Compare mode
  localparam logic [7:0] OFS_THR  = 8'h10; // Compare threshold
  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int START_BIT = 7;   // Conversion start
  localparam int RATE_LSB  = 3;   // Rate field low bit
  localparam int RATE_W    = 3;   // Rate field width
  localparam int EN_BIT    = 0;   // Converter enable
  localparam int CMP_EN    = 7;   // Compare enable
  localparam int CMP_COND  = 6;   // Condition select
  localparam int CHAN_W    = 3;   // Channel field width
  localparam int RES_W     = 10;  // Conversion bits
  localparam int RES_PAD   = 6;   // Zero pad bits
  localparam int RES_MSB   = 15;  // Result top bit
  localparam int THR_W     = 8;   // Threshold width
  localparam int CNT_W     = 9;   // Cycle counter width
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [RES_W-1:0] SAR_INIT = 10'h200;
  localparam logic [3:0] SAR_TOP = 4'h9;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ****************************************
  // Rate timing in system clock cycles
  // ****************************************
  typedef struct packed {
    logic [CNT_W-1:0] conv; // Whole conversion
    logic [CNT_W-1:0] samp; // Sampling part
    logic [CNT_W-1:0] step; // One bit decision
    logic [CNT_W-1:0] dly;  // Start delay
  } apfc_tim_t;
  localparam apfc_tim_t TIM_0 = {9'h120, 9'h028, 9'h018, 9'h020};
  localparam apfc_tim_t TIM_1 = {9'h0f0, 9'h020, 9'h014, 9'h01c};
  localparam apfc_tim_t TIM_2 = {9'h0c0, 9'h018, 9'h010, 9'h018};
  localparam apfc_tim_t TIM_4 = {9'h090, 9'h014, 9'h00c, 9'h010};
  localparam apfc_tim_t TIM_5 = {9'h078, 9'h010, 9'h00a, 9'h00e};
  localparam apfc_tim_t TIM_6 = {9'h060, 9'h00c, 9'h008, 9'h00c};
  // Timing of a rate code; prohibited codes run slowest
  function automatic apfc_tim_t rate_timing(input logic [RATE_W-1:0] rate);
    case (rate)
      3'h1:    rate_timing = TIM_1;
      3'h2:    rate_timing = TIM_2;
      3'h4:    rate_timing = TIM_4;
      3'h5:    rate_timing = TIM_5;
      3'h6:    rate_timing = TIM_6;
      default: rate_timing = TIM_0;
    endcase
  endfunction
endpackage
`default_nettype wire

/* rtl/apfc_sar.sv */
// Successive approximation register stepping one bit per step pulse
`timescale 1ns/1ps
`default_nettype none
module apfc_sar
  import apfc_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Control from the sequencer
  input  wire logic             clear,
  input  wire logic             step,
  input  wire logic             cmp_high,
  // Trial value and result
  output logic [RES_W-1:0]      tap
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [RES_W-1:0] trial; // Trial code and result
    logic [3:0]       idx;   // Bit under decision
    logic             busy;  // Decisions remain
  } apfc_sar_t;
  apfc_sar_t r;   // Registered state
  apfc_sar_t n;   // Next state

  // Next state: keep or drop bit, then try next one
  always_comb
  begin
    n = r;
    if (clear)
    begin
      n.trial = SAR_INIT;
      n.idx   = SAR_TOP;
      n.busy  = 1'b1;
    end
    else if (step && r.busy)
    begin
      // Drop bit when input below tap
      if (!cmp_high)
        n.trial[r.idx] = 1'b0;
      if (r.idx != 4'h0)
      begin
        n.trial[r.idx - 4'h1] = 1'b1;
        n.idx = r.idx - 4'h1;
      end
      else
        n.busy = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= n;
  end

  assign tap = r.trial;

  // Clear loads the mid-scale trial code
  sar_init_a: assert property (@(posedge clk) disable iff (!rst_n) // R17
    clear |=> (r.trial == SAR_INIT && r.busy))
    else $error("trial code not at mid-scale after clear");
endmodule
`default_nettype wire

/* bench/apfc_afe_model.sv */
// Behavioural analog front end: eight pin levels, sample switch, comparator
`timescale 1ns/1ps
`default_nettype none
module apfc_afe_model
  import apfc_pkg::*;
#(
  parameter logic [79:0] LVLS = 80'h0
)
(
  // Design side
  input  wire logic              clk,
  input  wire logic [CHAN_W-1:0] ch_sel,
  input  wire logic              sample_hold,
  input  wire logic [RES_W-1:0]  dac_tap,
  // Comparator result
  output logic                   cmp_high
);
  logic [RES_W-1:0] held = '0; // Level on the hold capacitor
  // Follow the selected pin while the switch is closed, keep it after
  always_ff @(posedge clk)
  begin
    if (sample_hold)
      held <= LVLS[ch_sel*10 +: 10];
  end
  // Held level at or above the tap reads high
  assign cmp_high = (held >= dac_tap);
endmodule
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import apfc_pkg::*;
  typedef struct packed
  {
    logic [2:0] ch;
    logic [2:0] rate;
    logic [7:0] cmpm;
    logic [7:0] thr;
    logic [1:0] nirq;
  } apfc_row_t;
  // Pin levels of channels 7 down to 0
  localparam logic [79:0] LVLS =
    {10'h1ff, 10'h200, 10'h301, 10'h0c7, 10'h2aa, 10'h155, 10'h3ff, 10'h000};
  localparam int LIMIT = 20000; // Cycle ceiling of the whole run
  int conv_tab [8] = '{288, 240, 192, 288, 144, 120, 96, 288};
  int dly_tab [8] = '{32, 28, 24, 32, 16, 14, 12, 32};
  // Table rows: channel, rate, compare mode, threshold, interrupts
  apfc_row_t rows [11] = '{
    '{3'd1, 3'd0, 8'h00, 8'h00, 2'd2}, '{3'd2, 3'd1, 8'h00, 8'h00, 2'd2},
    '{3'd3, 3'd2, 8'h00, 8'h00, 2'd2}, '{3'd4, 3'd4, 8'h00, 8'h00, 2'd2},
    '{3'd5, 3'd5, 8'h00, 8'h00, 2'd2}, '{3'd6, 3'd6, 8'h00, 8'h00, 2'd2},
    '{3'd7, 3'd3, 8'h00, 8'h00, 2'd2}, '{3'd2, 3'd6, 8'h80, 8'h55, 2'd2},
    '{3'd2, 3'd6, 8'h80, 8'h56, 2'd0}, '{3'd2, 3'd6, 8'hc0, 8'h56, 2'd2},
    '{3'd2, 3'd6, 8'hc0, 8'h55, 2'd0}};
  logic [7:0] regs [5] = '{OFS_MODE, OFS_CHAN, OFS_RES, OFS_CMPM, OFS_THR};
  logic [7:0] waddr [4] = '{OFS_CHAN, OFS_THR, OFS_CMPM, OFS_MODE};
  logic [7:0] wval [4] = '{8'h03, 8'h10, 8'h00, 8'h81};
  // Bench-driven inputs
  logic clk_sys = 1'b0, rst_n = 1'b0, standby = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  // Design outputs
  logic awready, wready, bvalid, arready, rvalid, cmp_high, sample_hold;
  logic conv_enable, irq;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [2:0] ch_sel;
  logic [9:0] dac_tap;
  int cyc = 0, irq_n = 0, last_irq = 0, prev_irq = 0, wr_cyc = 0, n0 = 0;
  int miscompares = 0, num_checks = 0;

  apfc_top u_apfc_top (.CLK_SYS(clk_sys), .RST_N(rst_n),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .CMP_HIGH(cmp_high),
    .CH_SEL(ch_sel), .SAMPLE_HOLD(sample_hold), .DAC_TAP(dac_tap),
    .CONV_ENABLE(conv_enable), .STANDBY(standby), .CONV_END_IRQ(irq));
  apfc_afe_model #(.LVLS(LVLS)) u_apfc_afe_model (.clk(clk_sys),
    .ch_sel(ch_sel), .sample_hold(sample_hold), .dac_tap(dac_tap),
    .cmp_high(cmp_high));

  // Clock of 10 ns
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end
  // Cycle count, interrupt stamps and hang guard
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (irq === 1'b1)
    begin
      irq_n <= irq_n + 1;
      prev_irq <= last_irq;
      last_irq <= cyc;
    end
    if (cyc > LIMIT)
    begin
      miscompares++;
      final_report;
    end
  end

  // Expected result word of a channel, left-justified
  function automatic logic [31:0] exp_res(input logic [2:0] ch);
    exp_res = {16'h0, LVLS[ch*10 +: 10], 6'h0};
  endfunction
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One AXI4-Lite write, response kept in r
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    r = bresp;
    wr_cyc = cyc;
  endtask
  // One AXI4-Lite read, data in d and response in r
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    r = rresp;
    d = rdata;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    wait_n(4);
    for (int i = 0; i < 5; i++)
    begin
      rd(regs[i]);
      chk("reset value", d, 32'h0);
    end
    $display("test reset done");
    // Enable well ahead of the first start, kept on through the rows
    wr(OFS_MODE, 32'h1);
    wait_n(1400);
    // Ordinary cases, one start from idle per row
    for (int i = 0; i < 11; i++)
    begin
      wr(OFS_MODE, 32'h1);
      wr(OFS_CHAN, {29'h0, rows[i].ch});
      wr(OFS_CMPM, {24'h0, rows[i].cmpm});
      wr(OFS_THR, {24'h0, rows[i].thr});
      n0 = irq_n;
      wr(OFS_MODE, {24'h0, 2'b10, rows[i].rate, 3'b001});
      wait_n(dly_tab[rows[i].rate] + conv_tab[rows[i].rate] * 5 / 2);
      chk("irq count", irq_n - n0, {30'h0, rows[i].nirq});
      if (rows[i].nirq != 2'd0)
        chk("irq interval", last_irq - prev_irq, conv_tab[rows[i].rate]);
      rd(OFS_RES);
      chk("result", d, exp_res(rows[i].ch));
      chk("channel pin", {29'h0, ch_sel}, {29'h0, rows[i].ch});
      $display("test row %0d done", i);
    end
    // Writes in mid-conversion restart it, channel change at the slowest rate
    wr(OFS_MODE, 32'h0);
    wr(OFS_CMPM, 32'h0);
    wr(OFS_CHAN, 32'h1);
    wr(OFS_MODE, 32'h81);
    wait_n(420);
    for (int i = 0; i < 4; i++)
    begin
      n0 = irq_n;
      wr(waddr[i], {24'h0, wval[i]});
      wait_n(296);
      chk("restart count", irq_n - n0, 32'h1);
      chk("restart time", {31'h0, (last_irq - wr_cyc) inside {[283:293]}}, 32'h1);
      wait_n(100);
    end
    rd(OFS_RES);
    chk("new channel result", d, exp_res(3'd3));
    $display("test restart done");
    // Clearing start halts at once
    n0 = irq_n;
    wr(OFS_MODE, 32'h01);
    wait_n(600);
    chk("halt irq count", irq_n - n0, 32'h0);
    chk("halt sampling", {31'h0, sample_hold}, 32'h0);
    chk("enable pin", {31'h0, conv_enable}, 32'h1);
    $display("test halt done");
    // Standby stops, leaving it resumes
    wr(OFS_MODE, 32'h81);
    wait_n(100);
    n0 = irq_n;
    standby <= 1'b1;
    wait_n(600);
    chk("standby irq count", irq_n - n0, 32'h0);
    standby <= 1'b0;
    wait_n(328);
    chk("resume irq count", irq_n - n0, 32'h1);
    $display("test standby done");
    // Refused and read-only places
    wr(OFS_MODE, 32'h0);
    chk("enable pin off", {31'h0, conv_enable}, 32'h0);
    wr(8'h14, 32'hff);
    chk("unmapped write resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    rd(8'h14);
    chk("unmapped read resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    chk("unmapped read data", d, 32'h0);
    wr(OFS_RES, 32'hffff);
    chk("result write resp", {30'h0, r}, {30'h0, RESP_OKAY});
    rd(OFS_RES);
    chk("result kept", d, exp_res(3'd3));
    wr(OFS_CMPM, 32'hff);
    rd(OFS_CMPM);
    chk("compare mode bits", d, 32'hc0);
    wstrb <= 4'he;
    wr(OFS_THR, 32'h77);
    wstrb <= 4'hf;
    chk("strobe off resp", {30'h0, r}, {30'h0, RESP_OKAY});
    rd(OFS_THR);
    chk("strobe off kept", d, 32'h10);
    $display("test refused done");
    // Reset in mid-conversion clears every register and stops work
    n0 = irq_n;
    wr(OFS_MODE, 32'h81);
    wait_n(200);
    rst_n <= 1'b0;
    wait_n(3);
    chk("reset enable pin", {31'h0, conv_enable}, 32'h0);
    rst_n <= 1'b1;
    wait_n(4);
    for (int i = 0; i < 5; i++)
    begin
      rd(regs[i]);
      chk("mid reset value", d, 32'h0);
    end
    wait_n(300);
    chk("reset irq count", irq_n - n0, 32'h0);
    $display("test mid reset done");
    final_report;
  end
endmodule
`default_nettype wire
